/* File: include/vic_cfg.svh */
`ifndef VIC_CFG_SVH
`define VIC_CFG_SVH
`define VIC_IVT_BASE      24'h000004
`define VIC_RESET_ADDR    24'h000000
`define VIC_NUM_TRAPS     8
`define VIC_NUM_IRQS      118
`define VIC_NUM_VECT      126
`define VIC_VECT_BYTES    24'h000002
`define VIC_OFF_INTERRUPT_CONTROL_TWO   8'h00
`define VIC_OFF_PRIORITY_CONTROL_6      8'h01
`define VIC_OFF_PRIORITY_CONTROL_8      8'h02
`define VIC_OFF_CPU_LVL   8'h03
`define VIC_OFF_STATUS    8'h04
`define VIC_OFF_MASK      8'h05
`define VIC_OFF_VECTOR    8'h06
`define VIC_OFF_PEND_LVL  8'h07
`define VIC_ALT_BIT       15
`define VIC_IPC_RST       16'h4444
`define VIC_IPC_WMASK     16'h7777
`define VIC_LVL_RST       3'h0
`define VIC_SRC_T4        0
`define VIC_SRC_OC4       1
`define VIC_SRC_OC3       2
`define VIC_SRC_DMA2      3
`define VIC_SRC_CROLL     4
`define VIC_SRC_CFREE     5
`define VIC_SRC_SPI2TX    6
`define VIC_SRC_SPI2      7
`endif

/* File: include/vic_pkg.sv */
package vic_pkg;
	typedef logic [2:0] vic_level_t;
	typedef enum logic [1:0] {
		VIC_EV_TRAP,
		VIC_EV_IRQ,
		VIC_EV_ACK
	} vic_event_t;
endpackage

/* File: rtl/vic_top.sv */
`timescale 1ns/1ps
`include "vic_cfg.svh"
module vic_top
	import vic_pkg::*;
#(
	parameter int NTRAP = `VIC_NUM_TRAPS,
	parameter int NIRQ  = `VIC_NUM_IRQS
) (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic [7:0]        addr,
	input  wire logic [15:0]       wdata,
	input  wire logic              wr,
	input  wire logic              rd,
	output logic      [15:0]       rdata,
	input  wire logic [NTRAP-1:0]  trap_req,
	input  wire logic [NIRQ-1:0]   irq_req,
	input  wire logic              irq_ack,
	output logic                   cpu_req,
	output logic                   cpu_trap,
	output logic      [23:0]       vector_addr,
	output logic      [6:0]        vector_num,
	output logic      [2:0]        vector_level,
	output logic                   irq_out
);
	localparam int NV = NTRAP + NIRQ;

	// structure, front to back: reset release, register file, per-source levels,
	// arbitration, vector address, core request stage, sticky status, read port.
	// every output leaves a flop, and the request path has exactly one stage,
	// so the time from a request to cpu_req is the same for every source.
	//
	// register indices on the plain port:
	//   0  control two, only bit 15 (alternate table select) is kept
	//   1  priority control 6, four 3-bit level fields, pads read zero
	//   2  priority control 8, same layout
	//   3  core level, the level the core is running at
	//   4  status, write one to clear: ack, interrupt forwarded, trap seen
	//   5  mask, same layout as status, drives irq_out
	//   6  winning vector number, read-only
	//   7  request flag and winning level, read-only
	//
	// limitation: only the eight sources with a field here are programmable;
	// every other source competes at the reset level 4

	////////////////////////////////////////////////////////////////////////////
	// reset release through two flops; assertion is immediate, release is clean
	logic rst_s1_q;
	logic rst_s2_q;

	// first stage takes the constant high once the pin lets go
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
		end
	end

	// second stage is the only reader of the first
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s2_q <= 1'b0;
		end else begin
			rst_s2_q <= rst_s1_q;
		end
	end

	// internal active-low reset for everything else
	wire rst_ok_n = rst_s2_q;

	////////////////////////////////////////////////////////////////////////////
	// registers
	logic [15:0] ctrl2_q;
	logic [15:0] priority_control_6_q;
	logic [15:0] priority_control_8_q;
	vic_level_t  cpu_lvl_q;
	logic [2:0]  stat_q;
	logic [2:0]  mask_q;

	// one-hot register select; the write decode and the read mux share it
	function automatic logic [7:0] reg_sel(input logic [7:0] a);
		reg_sel = 8'h00;
		if (a == `VIC_OFF_INTERRUPT_CONTROL_TWO) begin
			reg_sel[0] = 1'b1;
		end else if (a == `VIC_OFF_PRIORITY_CONTROL_6) begin
			reg_sel[1] = 1'b1;
		end else if (a == `VIC_OFF_PRIORITY_CONTROL_8) begin
			reg_sel[2] = 1'b1;
		end else if (a == `VIC_OFF_CPU_LVL) begin
			reg_sel[3] = 1'b1;
		end else if (a == `VIC_OFF_STATUS) begin
			reg_sel[4] = 1'b1;
		end else if (a == `VIC_OFF_MASK) begin
			reg_sel[5] = 1'b1;
		end else if (a == `VIC_OFF_VECTOR) begin
			reg_sel[6] = 1'b1;
		end else if (a == `VIC_OFF_PEND_LVL) begin
			reg_sel[7] = 1'b1;
		end
	endfunction

	// named selects; unmapped indices select nothing, so writes there are dropped
	wire [7:0] sel    = reg_sel(addr);
	wire       sel_c2 = sel[0];
	wire       sel_i6 = sel[1];
	wire       sel_i8 = sel[2];
	wire       sel_cl = sel[3];
	wire       sel_st = sel[4];
	wire       sel_mk = sel[5];
	wire       sel_vn = sel[6];
	wire       sel_pl = sel[7];

	// write enables; vector and pending-level indices are read-only
	wire       we_c2  = wr && sel_c2;
	wire       we_i6  = wr && sel_i6;
	wire       we_i8  = wr && sel_i8;
	wire       we_cl  = wr && sel_cl;
	wire       we_st  = wr && sel_st;
	wire       we_mk  = wr && sel_mk;

	// next values; only the alt bit of control two exists, pads stay zero
	wire [15:0] ctrl2_d   = we_c2 ? (wdata & 16'h8000) : ctrl2_q;
	wire [15:0] priority_control_6_d    = we_i6 ? (wdata & `VIC_IPC_WMASK) : priority_control_6_q;
	wire [15:0] priority_control_8_d    = we_i8 ? (wdata & `VIC_IPC_WMASK) : priority_control_8_q;
	wire [2:0]  cpu_lvl_d = we_cl ? wdata[2:0] : cpu_lvl_q;
	wire [2:0]  mask_d    = we_mk ? wdata[2:0] : mask_q;

	// control two
	always_ff @(posedge clk or negedge rst_ok_n) begin
		if (!rst_ok_n) begin
			ctrl2_q <= 16'h0000;
		end else begin
			ctrl2_q <= ctrl2_d;
		end
	end

	// priority control 6, every field at level 4 out of reset
	always_ff @(posedge clk or negedge rst_ok_n) begin
		if (!rst_ok_n) begin
			priority_control_6_q <= `VIC_IPC_RST;
		end else begin
			priority_control_6_q <= priority_control_6_d;
		end
	end

	// priority control 8, same reset as control 6
	always_ff @(posedge clk or negedge rst_ok_n) begin
		if (!rst_ok_n) begin
			priority_control_8_q <= `VIC_IPC_RST;
		end else begin
			priority_control_8_q <= priority_control_8_d;
		end
	end

	// core level; zero lets every enabled source through
	always_ff @(posedge clk or negedge rst_ok_n) begin
		if (!rst_ok_n) begin
			cpu_lvl_q <= `VIC_LVL_RST;
		end else begin
			cpu_lvl_q <= cpu_lvl_d;
		end
	end

	// interrupt mask
	always_ff @(posedge clk or negedge rst_ok_n) begin
		if (!rst_ok_n) begin
			mask_q <= 3'h0;
		end else begin
			mask_q <= mask_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// per-source levels; unnamed sources default to level 4 in this build
	function automatic vic_level_t fld(input logic [15:0] r, input int k);
		fld = r[k*4 +: 3];
	endfunction

	// named fields of the two priority registers
	wire [2:0] timer4_priority             = fld(priority_control_6_q, 3);
	wire [2:0] compare4_priority           = fld(priority_control_6_q, 2);
	wire [2:0] compare3_priority           = fld(priority_control_6_q, 1);
	wire [2:0] dma_channel2_priority       = fld(priority_control_6_q, 0);
	wire [2:0] crypto_rollover_priority    = fld(priority_control_8_q, 3);
	wire [2:0] crypto_buffer_free_priority = fld(priority_control_8_q, 2);
	wire [2:0] spi2_transmit_priority      = fld(priority_control_8_q, 1);
	wire [2:0] spi2_general_priority       = fld(priority_control_8_q, 0);

	// level per source; the rest have no field here and sit at level 4
	vic_level_t lvl [NIRQ];
	always_comb begin
		for (int i = 0; i < NIRQ; i++) lvl[i] = 3'h4;
		lvl[`VIC_SRC_T4]     = timer4_priority;
		lvl[`VIC_SRC_OC4]    = compare4_priority;
		lvl[`VIC_SRC_OC3]    = compare3_priority;
		lvl[`VIC_SRC_DMA2]   = dma_channel2_priority;
		lvl[`VIC_SRC_CROLL]  = crypto_rollover_priority;
		lvl[`VIC_SRC_CFREE]  = crypto_buffer_free_priority;
		lvl[`VIC_SRC_SPI2TX] = spi2_transmit_priority;
		lvl[`VIC_SRC_SPI2]   = spi2_general_priority;
	end

	////////////////////////////////////////////////////////////////////////////
	// arbitration: scan descending so the lowest vector overwrites last
	// a loop encoder is slower than a tree, but short and plainly fixed-order
	logic            trap_hit;
	logic [6:0]      trap_num;
	logic            irq_hit;
	logic [6:0]      irq_num;
	vic_level_t      irq_lvl;
	logic [NIRQ-1:0] irq_live;

	// sources that may compete: requesting and not disabled by a zero level
	always_comb begin
		for (int i = 0; i < NIRQ; i++) begin
			irq_live[i] = irq_req[i] && (lvl[i] != 3'h0);
		end
	end

	// trap encoder; traps outrank interrupts, so no level is needed here
	always_comb begin
		trap_hit = 1'b0;
		trap_num = 7'h00;
		for (int t = NTRAP - 1; t >= 0; t--) begin
			if (trap_req[t]) begin
				trap_hit = 1'b1;
				trap_num = 7'(t);
			end
		end
	end

	// interrupt encoder; >= keeps the lower vector on a level tie
	always_comb begin
		irq_hit = 1'b0;
		irq_num = 7'h00;
		irq_lvl = 3'h0;
		for (int i = NIRQ - 1; i >= 0; i--) begin
			if (irq_live[i] && lvl[i] >= irq_lvl) begin
				irq_hit = 1'b1;
				irq_num = 7'(NTRAP + i);
				irq_lvl = lvl[i];
			end
		end
	end

	// traps are non-maskable and outrank any interrupt
	// an interrupt at or below the core level is held off, not dropped
	wire        irq_go   = irq_hit && (irq_lvl > cpu_lvl_q);
	wire        any_go   = trap_hit || irq_go;
	wire [6:0]  win_num  = trap_hit ? trap_num : irq_num;
	wire [2:0]  win_lvl  = trap_hit ? 3'h7 : irq_lvl;

	// vector address: base + num*2 bytes, alternate table right after primary
	// the alternate table starts NV entries later, so it matches entry for entry
	// the step is a constant two, so the product costs no multiplier
	function automatic logic [23:0] vaddr(input logic [6:0] n, input logic alt);
		logic [23:0] idx;
		idx = {17'h00000, n} + (alt ? 24'(NV) : 24'h000000);
		vaddr = `VIC_IVT_BASE + idx * `VIC_VECT_BYTES;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// request to core: one registered stage for every source, fixed latency
	// the winner is sampled whole, so number, level and address always agree
	wire        cpu_req_d      = any_go;
	wire        cpu_trap_d     = trap_hit;
	wire [23:0] vector_addr_d  = vaddr(win_num, ctrl2_q[`VIC_ALT_BIT]);
	wire [6:0]  vector_num_d   = win_num;
	wire [2:0]  vector_level_d = win_lvl;

	// request line
	always_ff @(posedge clk or negedge rst_ok_n) begin
		if (!rst_ok_n) begin
			cpu_req <= 1'b0;
		end else begin
			cpu_req <= cpu_req_d;
		end
	end

	// trap flag
	always_ff @(posedge clk or negedge rst_ok_n) begin
		if (!rst_ok_n) begin
			cpu_trap <= 1'b0;
		end else begin
			cpu_trap <= cpu_trap_d;
		end
	end

	// vector address; reset shows the reset address
	always_ff @(posedge clk or negedge rst_ok_n) begin
		if (!rst_ok_n) begin
			vector_addr <= `VIC_RESET_ADDR;
		end else begin
			vector_addr <= vector_addr_d;
		end
	end

	// winner number
	always_ff @(posedge clk or negedge rst_ok_n) begin
		if (!rst_ok_n) begin
			vector_num <= 7'h00;
		end else begin
			vector_num <= vector_num_d;
		end
	end

	// winner level
	always_ff @(posedge clk or negedge rst_ok_n) begin
		if (!rst_ok_n) begin
			vector_level <= 3'h0;
		end else begin
			vector_level <= vector_level_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sticky status: bit0 trap seen, bit1 irq forwarded, bit2 ack; set beats clear
	wire [2:0] ev        = {irq_ack, irq_go, trap_hit};
	wire [2:0] clr       = we_st ? wdata[2:0] : 3'h0;
	wire [2:0] stat_d    = (stat_q & ~clr) | ev;
	// irq_out follows the next status, so it rises in the same cycle as the bit
	wire       irq_out_d = |(stat_d & mask_q);

	// status bits
	always_ff @(posedge clk or negedge rst_ok_n) begin
		if (!rst_ok_n) begin
			stat_q <= 3'h0;
		end else begin
			stat_q <= stat_d;
		end
	end

	// level interrupt
	always_ff @(posedge clk or negedge rst_ok_n) begin
		if (!rst_ok_n) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= irq_out_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read path, data one cycle after rd; unmapped indices read zero
	logic [15:0] rmux;
	always_comb begin
		rmux = 16'h0000;
		if (sel_c2) begin
			rmux = ctrl2_q;
		end else if (sel_i6) begin
			rmux = priority_control_6_q;
		end else if (sel_i8) begin
			rmux = priority_control_8_q;
		end else if (sel_cl) begin
			rmux = {13'h0000, cpu_lvl_q};
		end else if (sel_st) begin
			rmux = {13'h0000, stat_q};
		end else if (sel_mk) begin
			rmux = {13'h0000, mask_q};
		end else if (sel_vn) begin
			rmux = {9'h000, vector_num};
		end else if (sel_pl) begin
			rmux = {12'h000, cpu_req, vector_level};
		end
	end

	// rdata returns to zero outside the answer cycle
	always_ff @(posedge clk or negedge rst_ok_n) begin
		if (!rst_ok_n) begin
			rdata <= 16'h0000;
		end else begin
			rdata <= rd ? rmux : 16'h0000;
		end
	end
endmodule

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	logic         clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, rd_q = 1'b0;
	logic         irq_ack, cpu_req, cpu_trap, irq_out;
	logic [7:0]   addr = 8'h00, trap_req = 8'h00;
	logic [15:0]  wdata = 16'h0000, rdata;
	logic [16:0]  lfsr = 17'h10036;
	logic [117:0] irq_req = '0;
	logic [23:0]  vector_addr;
	logic [6:0]   vector_num;
	logic [2:0]   vector_level;
	logic [3:0]   delay = 4'h0;
	logic [15:0]  exp_q[$];
	int           mismatches = 0, check_count = 0;
	vic_top u_vic_top (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.trap_req(trap_req), .irq_req(irq_req), .irq_ack(irq_ack), .cpu_req(cpu_req), .cpu_trap(cpu_trap),
		.vector_addr(vector_addr), .vector_num(vector_num), .vector_level(vector_level), .irq_out(irq_out));
	vic_core_model u_vic_core_model (.clk(clk), .rst_n(rst_n), .delay(delay), .cpu_req(cpu_req), .irq_ack(irq_ack));
	function automatic logic [16:0] lfsr_next(input logic [16:0] s);
		lfsr_next = {s[15:0], s[16] ^ s[13]};
	endfunction
	task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// one bus cycle; a read notes its expected word for the monitor
	task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= w;
		rd    <= !w;
		if (!w) exp_q.push_back(d);
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	initial forever #5 clk = ~clk;
	////////////////////////////////////////////////////////////////////////////
	// read data stand only in the cycle after the strobe
	always @(posedge clk) begin
		rd_q <= rd;
		if (rd_q) check("rdata", rdata, exp_q.pop_front());
	end
	initial begin
		repeat (5000) @(posedge clk);
		mismatches++;
		tally_and_finish;
	end
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		bus(0, 8'h01, 16'h4444);
		bus(0, 8'h02, 16'h4444);
		bus(0, 8'h09, 16'h0000);
		bus(1, 8'h01, 16'hFFFF);
		bus(0, 8'h01, 16'h7777);
		// one field at level 7 beats random traffic at the fixed level 4
		for (int k = 0; k < 8; k++) begin
			lfsr = lfsr_next(lfsr);
			irq_req <= {110'({7{lfsr}}), 8'hFF};
			bus(1, 8'h01, k < 4 ? 16'h7000 >> 4 * k : 16'h0000);
			bus(1, 8'h02, k < 4 ? 16'h0000 : 16'h7000 >> 4 * (k - 4));
			bus(0, 8'h06, 16'(8 + k));
			bus(0, 8'h07, 16'h000F);
			check("vector_addr", vector_addr, 24'(4 + 2 * (8 + k)));
		end
		bus(1, 8'h01, 16'h4444);
		bus(1, 8'h02, 16'h4444);
		irq_req <= 118'h0F0;
		bus(0, 8'h06, 16'h000C);
		bus(1, 8'h02, 16'h0444);
		bus(0, 8'h06, 16'h000D);
		bus(1, 8'h03, 16'h0004);
		repeat (2) @(posedge clk);
		#1 check("cpu_req", cpu_req, 1'b0);
		bus(1, 8'h03, 16'h0003);
		bus(0, 8'h07, 16'h000C);
		delay <= 4'h5;
		trap_req <= 8'h06;
		bus(1, 8'h00, 16'h8000);
		bus(0, 8'h00, 16'h8000);
		bus(0, 8'h06, 16'h0001);
		check("vector_addr", vector_addr, 24'h000102);
		check("cpu_trap", cpu_trap, 1'b1);
		repeat (8) @(posedge clk);
		bus(0, 8'h04, 16'h0007);
		trap_req <= 8'h00;
		irq_req <= '0;
		repeat (3) @(posedge clk);
		bus(1, 8'h04, 16'h0007);
		bus(0, 8'h04, 16'h0000);
		bus(1, 8'h05, 16'h0001);
		trap_req <= 8'h01;
		repeat (3) @(posedge clk);
		#1 check("irq_out", irq_out, 1'b1);
		@(posedge clk);
		trap_req <= 8'h00;
		bus(1, 8'h04, 16'h0001);
		repeat (2) @(posedge clk);
		#1 check("irq_out", irq_out, 1'b0);
		tally_and_finish;
	end
endmodule

/* File: sim/vic_core_model.sv */
`timescale 1ns/1ps
// stands in for the core; acknowledges a held request after a settable wait
module vic_core_model (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [3:0] delay,
	input  wire logic       cpu_req,
	output logic            irq_ack
);
	logic [3:0] cnt_q;
	// count while the single request line stands; a slow core just waits longer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q   <= 4'h0;
			irq_ack <= 1'b0;
		end else begin
			cnt_q   <= cpu_req ? cnt_q + 4'h1 : 4'h0;
			irq_ack <= cpu_req && cnt_q == delay;
		end
	end
endmodule

/* File: sim/vic_top_sva.sv */
`timescale 1ns/1ps
module vic_top_sva #(
	parameter int NTRAP = 8,
	parameter int NIRQ  = 118
) (
	input wire logic             clk,
	input wire logic             rst_n,
	input wire logic [7:0]       addr,
	input wire logic             rd,
	input wire logic [15:0]      rdata,
	input wire logic [NTRAP-1:0] trap_req,
	input wire logic [NIRQ-1:0]  irq_req,
	input wire logic             cpu_req,
	input wire logic             cpu_trap,
	input wire logic [23:0]      vector_addr,
	input wire logic [6:0]       vector_num,
	input wire logic [2:0]       vector_level
);
	logic [1:0] up_q;
	wire        live = up_q == 2'h3;
	// internal reset trails the pin by two edges; checks stay off for three edges
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n) up_q <= 2'h0;
		else if (!live) up_q <= up_q + 2'h1;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n || !live);
	property p_trap_fwd; |trap_req |=> cpu_req && cpu_trap && vector_level == 3'h7; endproperty
	a_trap_fwd: assert property (p_trap_fwd) else $error("trap not forwarded");
	property p_idle; !(|trap_req) && !(|irq_req) |=> !cpu_req; endproperty
	a_idle: assert property (p_idle) else $error("request with nothing pending");
	property p_vaddr; cpu_req |-> vector_addr == 24'h4 + 24'(vector_num) * 2 ||
		vector_addr == 24'h100 + 24'(vector_num) * 2; endproperty
	a_vaddr: assert property (p_vaddr) else $error("vector address off table");
	property p_trap_num; cpu_trap |-> vector_num < 7'h08; endproperty
	a_trap_num: assert property (p_trap_num) else $error("trap number out of range");
	property p_irq_num; cpu_req && !cpu_trap |-> vector_num >= 7'h08 && vector_level != 3'h0; endproperty
	a_irq_num: assert property (p_irq_num) else $error("bad source number or level");
	property p_trap0; trap_req[0] |=> vector_num == 7'h00; endproperty
	a_trap0: assert property (p_trap0) else $error("vector 0 lost");
	property p_pad; rd && (addr == 8'h01 || addr == 8'h02) |=> (rdata & 16'h8888) == 16'h0000; endproperty
	a_pad: assert property (p_pad) else $error("unused priority bit set");
	property p_lat; $rose(cpu_req) |-> $past(|trap_req) || $past(|irq_req); endproperty
	a_lat: assert property (p_lat) else $error("request without cause");
endmodule
bind vic_top vic_top_sva #(.NTRAP(NTRAP), .NIRQ(NIRQ)) u_vic_top_sva (.clk(clk), .rst_n(rst_n), .addr(addr),
	.rd(rd), .rdata(rdata), .trap_req(trap_req), .irq_req(irq_req), .cpu_req(cpu_req), .cpu_trap(cpu_trap),
	.vector_addr(vector_addr), .vector_num(vector_num), .vector_level(vector_level));
